//--- dv/dq_ddr_read_sva.sv
// port assertions of the double-rate quad read path
`timescale 1ns/10ps
`default_nettype none
module dq_ddr_read_sva #(parameter int ARRAY_AW = 24) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic SCK_IN,
  input wire logic CS_N_IN,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE_OUT,
  input wire logic [ARRAY_AW-1:0] MEM_ADDR_OUT,
  input wire logic MEM_RD_OUT,
  input var dq_pkg::dq_state_type STATE_OUT
);
  import dq_pkg::*;
  logic [ARRAY_AW-1:0] last_r, last_nxt;
  always_comb last_nxt = MEM_RD_OUT ? MEM_ADDR_OUT : last_r;
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      last_r <= {ARRAY_AW{1'b0}};
    end else begin
      last_r <= last_nxt;
    end
  end
  // ==========
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence cs_idle; CS_N_IN [*5]; endsequence
  // pin edges take up to three cycles to reach the outputs
  sequence out_quiet; ($stable(SCK_IN) && IO_OE_OUT != 4'h0) [*4]; endsequence
  oe_same_a: assert property (IO_OE_OUT == 4'h0 || (IO_OE_OUT == 4'hf && STATE_OUT inside {ST_DUMMY, ST_DATA}))
    else $error("oe mix");
  cs_release_a: assert property (cs_idle |-> IO_OE_OUT == 4'h0 && STATE_OUT == ST_IDLE) else $error("no idle");
  rd_pulse_a: assert property (MEM_RD_OUT |=> !MEM_RD_OUT) else $error("rd long");
  addr_step_a: assert property (MEM_RD_OUT && STATE_OUT == ST_DATA |-> MEM_ADDR_OUT == last_r + 1'b1)
    else $error("addr step");
  ignore_quiet_a: assert property (STATE_OUT == ST_IGNORE |-> IO_OE_OUT == 4'h0 && !MEM_RD_OUT)
    else $error("ignore drive");
  out_hold_a: assert property (out_quiet |-> $stable(IO_OUT)) else $error("io moved");
  oe_phase_a: assert property ($rose(IO_OE_OUT[0]) |-> STATE_OUT inside {ST_DUMMY, ST_DATA})
    else $error("oe early");
  oe_stand_a: assert property ($fell(IO_OE_OUT[0]) |-> CS_N_IN && $past(CS_N_IN)) else $error("oe drop");
endmodule
bind dq_ddr_quad_read dq_ddr_read_sva #(.ARRAY_AW(ARRAY_AW)) dq_ddr_read_sva_i (.REF_CLK_IN(REF_CLK_IN),
  .RST_IN(RST_IN), .SCK_IN(SCK_IN), .CS_N_IN(CS_N_IN), .IO_OUT(IO_OUT), .IO_OE_OUT(IO_OE_OUT),
  .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_RD_OUT(MEM_RD_OUT), .STATE_OUT(STATE_OUT));
`default_nettype wire

//--- dv/dq_host_model.sv
// host controller model driving the serial side of the read path
`timescale 1ns/10ps
`default_nettype none
module dq_host_model (
  input wire logic clk,
  input wire logic [3:0] io_w,
  output logic sck,
  output logic cs_n,
  output logic [3:0] hio
);
  logic [3:0] q [$];
  logic [3:0] cap;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hio = 4'h0;
  end
  // ==========
  // half period of six ref cycles keeps sck far below 80 MHz
  task automatic h(input logic [3:0] d, input bit drv);
    @(posedge clk) hio <= drv ? d : ~hio; // released lines toggle, never a stale value
    repeat (3) @(posedge clk);
    cap = io_w;
    sck <= ~sck;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] op, input bit fw, input int nib, input logic [31:0] a, input int n);
    logic [3:0] d;
    q.delete();
    @(posedge clk) cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < (fw ? 2 : 8); i++) begin
      d = fw ? op[7-4*i -: 4] : {3'h0, op[7-i]};
      h(d, 1);
      h(d, 1);
    end
    for (int i = 0; i < nib; i++) h(a[4*nib-1-4*i -: 4], 1);
    h(4'h0, 1); // nibbles not complements: standard read
    h(4'h0, 1);
    for (int e = 0; e < n; e++) begin
      h(4'h0, 0);
      q.push_back(cap);
    end
    @(posedge clk) cs_n <= 1'b1; // low through mode, dummy and data
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench of the double-rate quad read path
`timescale 1ns/10ps
`default_nettype none
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s %h %h", w, e, g); end end
module tb_top;
  import dq_pkg::*;
  logic clk = 0, rst = 1, qen = 0, a4 = 0, fw = 0, pe = 0, mrd, sck, cs_n;
  logic [3:0] lat = 4'h0, io_out, io_oe, hio, io_w;
  logic [7:0] pat = 8'h00, mdat = 8'h00;
  logic [23:0] maddr;
  int err_total = 0, compares = 0, oe_cycles = 0;
  // ==========
  assign io_w = |io_oe ? io_out : hio;
  always @(posedge clk) mdat <= maddr[7:0] ^ maddr[23:16] ^ 8'h3c;
  always @(posedge clk) if (|io_oe) oe_cycles <= oe_cycles + 1;
  initial forever #2.5 clk = ~clk;
  dq_ddr_quad_read dq_ddr_quad_read_i (.REF_CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .CS_N_IN(cs_n), .IO_IN(io_w),
    .IO_OUT(io_out), .IO_OE_OUT(io_oe), .QUAD_EN_IN(qen), .ADDR4_SEL_IN(a4), .FOUR_WIRE_CMD_IN(fw),
    .LATENCY_IN(lat), .PREAMBLE_EN_IN(pe), .PREAMBLE_IN(pat), .MEM_ADDR_OUT(maddr), .MEM_RD_OUT(mrd),
    .MEM_DATA_IN(mdat), .STATE_OUT());
  dq_host_model dq_host_model_i (.clk(clk), .io_w(io_w), .sck(sck), .cs_n(cs_n), .hio(hio));
  task automatic run(input logic [7:0] op, input bit q, w, f, p, input logic [3:0] l, input logic [7:0] pt,
      input logic [31:0] a, input int nb);
    int le, oe0;
    logic [23:0] ea;
    logic [7:0] ex;
    le = (p && l < 4) ? 4 : int'(l);
    @(posedge clk) {qen, a4, fw, pe, lat, pat} <= {q, w, f, p, l, pt};
    oe0 = oe_cycles;
    dq_host_model_i.rd(op, f, (op == 8'hee || w) ? 8 : 6, a, 2 * le + 2 * nb);
    if (!q || !(op inside {8'hed, 8'hee})) begin
      `CHK("oe", 0, oe_cycles - oe0)
    end else begin
      for (int i = 0; i < 8 && p; i++) `CHK("pre", {4{pt[7-i]}}, dq_host_model_i.q[2*le-8+i])
      for (int i = 0; i < nb; i++) begin
        ea = a[23:0] + 24'(i);
        ex = ea[7:0] ^ ea[23:16] ^ 8'h3c;
        `CHK("hi", ex[7:4], dq_host_model_i.q[2*le+2*i])
        `CHK("lo", ex[3:0], dq_host_model_i.q[2*le+2*i+1])
      end
    end
    $display("test done %h", op);
  endtask
  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    run(8'hed, 1, 0, 0, 0, 4'h2, 8'h34, 32'h00fffffe, 3);
    run(8'hee, 1, 0, 1, 1, 4'h5, 8'h34, 32'h00a01234, 2);
    run(8'hed, 1, 1, 0, 1, 4'h1, 8'hc9, 32'h00000fff, 2);
    run(8'hed, 1, 0, 0, 0, 4'h0, 8'h00, 32'h00123456, 2);
    run(8'hed, 0, 0, 0, 0, 4'h2, 8'h00, 32'h00123456, 1);
    run(8'heb, 1, 0, 0, 0, 4'h2, 8'h00, 32'h00123456, 1);
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results;
  end
endmodule
`default_nettype wire

//--- src/dq_ddr_quad_read.sv
// device-side double-rate quad i/o read path
`timescale 1ns/10ps
`default_nettype none
`include "dq_map.svh"
module dq_ddr_quad_read #(
  parameter int ARRAY_AW = 24
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic SCK_IN,
  input wire logic CS_N_IN,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE_OUT,
  input wire logic QUAD_EN_IN,
  input wire logic ADDR4_SEL_IN,
  input wire logic FOUR_WIRE_CMD_IN,
  input wire logic [3:0] LATENCY_IN,
  input wire logic PREAMBLE_EN_IN,
  input wire logic [7:0] PREAMBLE_IN,
  output logic [ARRAY_AW-1:0] MEM_ADDR_OUT,
  output logic MEM_RD_OUT,
  input wire logic [7:0] MEM_DATA_IN,
  output var dq_pkg::dq_state_type STATE_OUT
);
  import dq_pkg::*;

  // ==========================================================
  // pin synchronisers
  // limitation: edges are seen after sampling, so the serial clock must be
  // well below the reference clock; sampling cost is about three ref cycles
  logic sck_s1_r, sck_s2_r, sck_d_r;
  logic cs_s1_r, cs_s2_r;
  logic [3:0] io_s1_r, io_s2_r;

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      sck_s1_r <= SCK_IN;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      cs_s1_r <= CS_N_IN;
      cs_s2_r <= cs_s1_r;
      io_s1_r <= IO_IN;
      io_s2_r <= io_s1_r;
    end
  end

  // each edge pulse lasts one ref cycle, so every step fires once
  logic rise, fall, any_edge;
  assign rise = sck_s2_r & ~sck_d_r;
  assign fall = ~sck_s2_r & sck_d_r;
  assign any_edge = rise | fall;

  // ==========================================================
  // command state
  // no continuous read mode, so each command starts from the opcode
  dq_state_type state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [5:0] nibs_r, nibs_nxt;
  logic [7:0] op_r, op_nxt;
  logic [31:0] cap_r, cap_nxt;
  logic [ARRAY_AW-1:0] addr_r, addr_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic half_r, half_nxt;
  logic rd_r, rd_nxt;
  logic rd_wait_r, rd_wait_nxt;
  logic [3:0] io_r, io_nxt;
  logic [3:0] oe_r, oe_nxt;
  logic [5:0] ec, first, pidx, last_cmd;
  logic [3:0] neff;
  logic dummy_go;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    nibs_nxt = nibs_r;
    op_nxt = op_r;
    cap_nxt = cap_r;
    addr_nxt = addr_r;
    byte_nxt = byte_r;
    half_nxt = half_r;
    rd_nxt = 1'b0;
    rd_wait_nxt = rd_r;
    io_nxt = io_r;
    oe_nxt = oe_r;
    // short latency grows to fit the preamble
    neff = (PREAMBLE_EN_IN && LATENCY_IN < `DQ_PRE_CYCLES) ? `DQ_PRE_CYCLES : LATENCY_IN;
    first = {1'b0, neff, 1'b0};
    ec = (state_r == ST_MODE) ? 6'h00 : 6'(cnt_r + 6'h01);
    // preamble bit index counts from its first edge, msb first
    pidx = 6'(ec + `DQ_PRE_EDGES - first);
    dummy_go = (state_r == ST_MODE && fall && cnt_r != 6'h00) || (state_r == ST_DUMMY && any_edge);
    last_cmd = FOUR_WIRE_CMD_IN ? `DQ_CMD_LAST_NIB : `DQ_CMD_LAST_BIT;
    // fetched byte arrives one cycle after the read strobe
    if (rd_wait_r) begin
      byte_nxt = MEM_DATA_IN;
    end
    // chip select high aborts any phase and frees the lines at once
    if (cs_s2_r) begin
      state_nxt = ST_IDLE;
      cnt_nxt = 6'h00;
      oe_nxt = 4'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_CMD;
          cnt_nxt = 6'h00;
          op_nxt = 8'h00;
        end
        ST_CMD: begin
          if (rise) begin
            op_nxt = FOUR_WIRE_CMD_IN ? {op_r[3:0], io_s2_r} : {op_r[6:0], io_s2_r[0]};
            cnt_nxt = 6'(cnt_r + 6'h01);
            if (cnt_r == last_cmd) begin
              cnt_nxt = 6'h00;
              cap_nxt = 32'h0;
              // without quad enable the command is not served
              if (QUAD_EN_IN && (op_nxt == `DQ_OP_READ_SEL || op_nxt == `DQ_OP_READ_4B)) begin
                state_nxt = ST_ADDR;
                nibs_nxt = (op_nxt == `DQ_OP_READ_4B || ADDR4_SEL_IN) ? `DQ_ADDR4_NIBS : `DQ_ADDR3_NIBS;
              end else begin
                state_nxt = ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR: begin
          // first nibble must come on a rising edge, the tail of the opcode cycle is skipped
          if (rise || (fall && cnt_r != 6'h00)) begin
            cap_nxt = {cap_r[27:0], io_s2_r};
            cnt_nxt = 6'(cnt_r + 6'h01);
            if (cnt_nxt == nibs_r) begin
              addr_nxt = cap_nxt[ARRAY_AW-1:0];
              rd_nxt = 1'b1;
              cnt_nxt = 6'h00;
              state_nxt = ST_MODE;
            end
          end
        end
        ST_MODE: begin
          // mode value is not examined: continuous mode is never entered
          if (rise && cnt_r == 6'h00) begin
            cnt_nxt = 6'h01;
          end
        end
        // dummy and data steps follow below; refused commands wait for chip select
        default: begin
        end
      endcase
      if (dummy_go) begin
        cnt_nxt = ec;
        state_nxt = ST_DUMMY;
        if (ec == first) begin
          io_nxt = byte_r[7:4];
          oe_nxt = 4'hf;
          half_nxt = 1'b1;
          state_nxt = ST_DATA;
        end else if (PREAMBLE_EN_IN && ec + `DQ_PRE_EDGES >= first) begin
          io_nxt = {4{PREAMBLE_IN[~pidx[2:0]]}};
          oe_nxt = 4'hf;
        end
      end
      // address steps after the upper nibble so the next fetch overlaps output
      if (state_r == ST_DATA && any_edge) begin
        if (half_r) begin
          io_nxt = byte_r[3:0];
          half_nxt = 1'b0;
          addr_nxt = ARRAY_AW'(addr_r + 1'b1);
          rd_nxt = 1'b1;
        end else begin
          io_nxt = byte_r[7:4];
          half_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= ST_IDLE;
      cnt_r <= 6'h00;
      nibs_r <= `DQ_ADDR3_NIBS;
      op_r <= 8'h00;
      cap_r <= 32'h0;
      addr_r <= '0;
      byte_r <= 8'h00;
      half_r <= 1'b0;
      rd_r <= 1'b0;
      rd_wait_r <= 1'b0;
      io_r <= 4'h0;
      oe_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      nibs_r <= nibs_nxt;
      op_r <= op_nxt;
      cap_r <= cap_nxt;
      addr_r <= addr_nxt;
      byte_r <= byte_nxt;
      half_r <= half_nxt;
      rd_r <= rd_nxt;
      rd_wait_r <= rd_wait_nxt;
      io_r <= io_nxt;
      oe_r <= oe_nxt;
    end
  end

  // every top output comes straight from a register
  assign IO_OUT = io_r;
  assign IO_OE_OUT = oe_r;
  assign MEM_ADDR_OUT = addr_r;
  assign MEM_RD_OUT = rd_r;
  assign STATE_OUT = state_r;
endmodule
`default_nettype wire

//--- src/dq_map.svh
// constants of the double-rate quad read path
// What this block does
// - opcode EDh uses 3 or 4 address bytes per setting; EEh always 4
// - address nibbles arrive on IO0-IO3 on both clock edges and are captured on both
// - after address and mode, read data leaves as a nibble on every clock edge
// - latency field sets dummy cycles before data; I/O values then are ignored
// - reading starts at any byte and the address steps by one per byte
// - past the top array address the counter wraps to zero and output continues
// - when enabled the preamble occupies the four cycles just before first data
// - preamble is a programmable byte, same bit on all four lines, one bit per edge
// - in four-wire command mode the opcode arrives as two nibbles on rising edges
`ifndef DQ_MAP_SVH
`define DQ_MAP_SVH
`define DQ_OP_READ_SEL 8'hed
`define DQ_OP_READ_4B 8'hee
`define DQ_CMD_LAST_BIT 6'h07
`define DQ_CMD_LAST_NIB 6'h01
`define DQ_ADDR3_NIBS 6'h06
`define DQ_ADDR4_NIBS 6'h08
`define DQ_PRE_CYCLES 4'h4
`define DQ_PRE_EDGES 6'h08
`endif

//--- src/dq_pkg.sv
// types of the double-rate quad read path
package dq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } dq_state_type;
endpackage
